// [logic/uart_optical.sv]
// Asynchronous serial port with mid-bit receiver, double-buffered transmitter and optical carrier
`timescale 1ns/1ps
module uart_optical
   import uart_optical_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Configuration and commands
   input  wire logic [15:0] baud_divisor_i,
   input  wire config_s     config_i,
   input  wire command_s    command_i,
   // Transmit data
   input  wire logic        tx_valid_i,
   output logic             tx_ready_o,
   input  wire logic [7:0]  tx_data_i,
   // Receive data
   output logic [7:0]       receive_holding_o,
   input  wire logic        rx_read_i,
   // Status and DMA requests
   output flag_s            flags_o,
   output logic             dma_rx_req_o,
   output logic             dma_tx_req_o,
   // Pins
   input  wire logic        serial_in_pin_i,
   input  wire logic        main_pll_clock_i,
   output logic             serial_out_pin_o
);

   // Parity bit for a character under a given setting
   function automatic logic parity_of(input logic [7:0] d, input logic [2:0] sel);
      logic p;
      p = 1'b0;
      case (sel)
         PAR_EVEN:  p = ^d;
         PAR_ODD:   p = ~(^d);
         PAR_SPACE: p = 1'b0;
         PAR_MARK:  p = 1'b1;
         default:   p = 1'b0;
      endcase
      return p;
   endfunction

   logic [15:0] baud_cnt_q;
   logic        tick;
   logic [2:0]  pin_sync_q;
   logic        pin_q;
   logic [2:0]  pll_sync_q;
   logic        pll_q;
   logic        pll_prev_q;
   logic        remote_mode;
   logic        rx_src;
   logic [2:0]  filt_q;
   logic        rx_line;
   rx_state_e   rx_st_q;
   logic        rx_stop_q;
   logic [2:0]  low_cnt_q;
   logic [3:0]  rx_tick_q;
   logic [3:0]  rx_idx_q;
   logic [7:0]  rx_shift_q;
   logic        rx_par_q;
   logic        rx_done;
   logic        rx_last;
   logic [7:0]  hold_q;
   logic        rdy_q;
   logic        ovr_q;
   logic        parity_error_flag_q;
   logic        frame_q;
   logic        clr_q;
   logic        tx_en_q;
   logic        tx_stop_q;
   logic [7:0]  thr_q;
   logic        thr_full_q;
   logic        buf_valid;
   logic        buf_ready;
   logic [7:0]  buf_data;
   tx_state_e   tx_st_q;
   logic [10:0] tx_shift_q;
   logic [3:0]  tx_left_q;
   logic [3:0]  tx_tick_q;
   logic        tx_line;
   logic        tx_load;
   logic [8:0]  car_period;
   logic [8:0]  car_high;
   logic [8:0]  car_cnt_q;
   logic        chan_out;
   logic        line_q;

   // baud divisor
   // Sampling tick every divisor clocks; a zero divisor halts the receiver and transmitter
   assign tick = (baud_divisor_i != 16'h0000) && (baud_cnt_q >= baud_divisor_i - 16'h0001);

   always_ff @(posedge clk_i) begin
      if (srst_i || tick || baud_divisor_i == 16'h0000) begin
         baud_cnt_q <= 16'h0000;
      end else begin
         baud_cnt_q <= baud_cnt_q + 16'h0001;
      end
   end

   // Pin synchronisers; a level counts once the second and third stages agree
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin_sync_q <= SYNC_RESET;
         pin_q      <= LINE_IDLE;
         pll_sync_q <= 3'h0;
         pll_q      <= 1'b0;
         pll_prev_q <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], serial_in_pin_i};
         pll_sync_q <= {pll_sync_q[1:0], main_pll_clock_i};
         pll_prev_q <= pll_q;
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_q <= pin_sync_q[2];
         end
         if (pll_sync_q[1] == pll_sync_q[2]) begin
            pll_q <= pll_sync_q[2];
         end
      end
   end

   // local loopback source
   // Local loopback takes the transmitter line and ignores the pin
   assign remote_mode = (config_i.channel_test_select == CH_REMOTE);
   assign rx_src      = (config_i.channel_test_select == CH_LOCAL) ? tx_line : pin_q;

   // majority filter
   // Three tick samples, two-of-three vote; costs a little start-edge latency
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         filt_q <= SYNC_RESET;
      end else if (tick) begin
         filt_q <= {filt_q[1:0], rx_src};
      end
   end

   assign rx_line = config_i.filter_enable ?
                    ((filt_q[0] & filt_q[1]) | (filt_q[1] & filt_q[2]) | (filt_q[0] & filt_q[2])) :
                    rx_src;

   assign rx_last = (config_i.parity_select == PAR_NONE) ? (rx_idx_q == PARITY_IDX)
                                                         : (rx_idx_q == PARITY_IDX + 4'h1);
   assign rx_done = (rx_st_q == RX_DATA) && tick && !remote_mode && rx_tick_q == TICK_LAST && rx_last;

   // Receiver state machine
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_st_q   <= RX_OFF;
         rx_stop_q <= 1'b0;
         low_cnt_q <= 3'h0;
         rx_tick_q <= 4'h0;
         rx_idx_q  <= 4'h0;
      end else if (command_i.receiver_reset_cmd) begin
         rx_st_q   <= RX_OFF;
         rx_stop_q <= 1'b0;
      end else begin
         case (rx_st_q)
            RX_OFF: begin
               if (command_i.receiver_enable_cmd && !command_i.receiver_disable_cmd) begin
                  rx_st_q <= RX_HUNT;
               end
            end
            RX_HUNT, RX_START: begin
               if (command_i.receiver_disable_cmd) begin
                  rx_st_q <= RX_OFF;
               end else if (tick && !remote_mode) begin
                  if (rx_line) begin
                     rx_st_q   <= RX_HUNT;
                     low_cnt_q <= 3'h0;
                  end else if (rx_st_q == RX_HUNT) begin
                     rx_st_q   <= RX_START;
                     low_cnt_q <= 3'h1;
                  end else if (low_cnt_q == START_LOW_LAST) begin
                     rx_st_q   <= RX_DATA;
                     rx_tick_q <= 4'h0;
                     rx_idx_q  <= 4'h0;
                  end else begin
                     low_cnt_q <= low_cnt_q + 3'h1;
                  end
               end
            end
            RX_DATA: begin
               // disable deferred until the stop bit
               if (command_i.receiver_disable_cmd) begin
                  rx_stop_q <= 1'b1;
               end
               // mid-bit sampling, 8 + 16 ticks to the first data bit
               if (tick && !remote_mode) begin
                  rx_tick_q <= rx_tick_q + 4'h1;
                  if (rx_tick_q == TICK_LAST) begin
                     rx_idx_q <= rx_idx_q + 4'h1;
                  end
               end
               if (rx_done) begin
                  rx_st_q   <= (rx_stop_q || command_i.receiver_disable_cmd) ? RX_OFF : RX_HUNT;
                  rx_stop_q <= 1'b0;
                  low_cnt_q <= 3'h0;
               end
            end
            default: rx_st_q <= RX_OFF;
         endcase
      end
   end

   // Receive data capture at each mid-bit sample
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_shift_q <= DATA_RESET;
         rx_par_q   <= 1'b0;
      end else if (rx_st_q == RX_DATA && tick && !remote_mode && rx_tick_q == TICK_LAST) begin
         if (rx_idx_q <= DATA_LAST_IDX) begin
            rx_shift_q <= {rx_line, rx_shift_q[7:1]};
         end else if (rx_idx_q == PARITY_IDX && config_i.parity_select != PAR_NONE) begin
            rx_par_q <= rx_line;
         end
      end
   end

   // clear-error command acts one cycle after it is given
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clr_q <= 1'b0;
      end else begin
         clr_q <= command_i.clear_error_flags_cmd;
      end
   end

   // Holding register and receive flags; a completing character wins over any clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hold_q  <= DATA_RESET;
         rdy_q   <= 1'b0;
         ovr_q   <= 1'b0;
         parity_error_flag_q  <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         if (rx_done) begin
            hold_q <= rx_shift_q;
            rdy_q  <= 1'b1;
         end else if (rx_read_i) begin
            rdy_q <= 1'b0;
         end
         // overrun when the previous character is still unread
         if (rx_done && rdy_q && !rx_read_i) begin
            ovr_q <= 1'b1;
         end else if (clr_q) begin
            ovr_q <= 1'b0;
         end
         if (rx_done && config_i.parity_select != PAR_NONE &&
             rx_par_q != parity_of(rx_shift_q, config_i.parity_select)) begin
            parity_error_flag_q <= 1'b1;
         end else if (clr_q) begin
            parity_error_flag_q <= 1'b0;
         end
         // framing check on the stop sample
         if (rx_done && !rx_line) begin
            frame_q <= 1'b1;
         end else if (clr_q) begin
            frame_q <= 1'b0;
         end
      end
   end

   // Writes queue here so a holding register that is busy never drops a word
   tx_skid_buffer #(
      .WIDTH (TX_BUF_WIDTH),
      .DEPTH (TX_BUF_DEPTH)
   ) u_tx_buf (
      .clk_i       (clk_i),
      .srst_i      (srst_i || command_i.transmitter_reset_cmd),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_ready),
      .out_data_o  (buf_data)
   );

   // holding register accepts only while enabled, empty and not draining
   assign buf_ready = tx_en_q && !tx_stop_q && !thr_full_q;
   assign tx_load   = thr_full_q && tx_st_q == TX_IDLE && !remote_mode;

   // Transmitter enable and deferred disable
   always_ff @(posedge clk_i) begin
      if (srst_i || command_i.transmitter_reset_cmd) begin
         tx_en_q   <= 1'b0;
         tx_stop_q <= 1'b0;
      end else if (command_i.transmitter_disable_cmd || tx_stop_q) begin
         // disable waits for shift and holding registers to drain
         if (tx_st_q == TX_IDLE && !thr_full_q) begin
            tx_en_q   <= 1'b0;
            tx_stop_q <= 1'b0;
         end else begin
            tx_stop_q <= 1'b1;
         end
      end else if (command_i.transmitter_enable_cmd) begin
         tx_en_q <= 1'b1;
      end
   end

   // Transmit holding register
   always_ff @(posedge clk_i) begin
      if (srst_i || command_i.transmitter_reset_cmd) begin
         thr_q      <= DATA_RESET;
         thr_full_q <= 1'b0;
      end else if (buf_valid && buf_ready) begin
         thr_q      <= buf_data;
         thr_full_q <= 1'b1;
      end else if (tx_load) begin
         thr_full_q <= 1'b0;
      end
   end

   // Transmit shifter, sixteen ticks per bit
   always_ff @(posedge clk_i) begin
      if (srst_i || command_i.transmitter_reset_cmd) begin
         tx_st_q    <= TX_IDLE;
         tx_shift_q <= '1;
         tx_left_q  <= 4'h0;
         tx_tick_q  <= 4'h0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               if (tx_load) begin
                  // frame layout, stop above parity above data above start
                  tx_st_q    <= TX_SHIFT;
                  tx_shift_q <= {1'b1, parity_of(thr_q, config_i.parity_select), thr_q, 1'b0};
                  tx_left_q  <= (config_i.parity_select == PAR_NONE) ? TX_BITS_NOPAR : TX_BITS_PAR;
                  tx_tick_q  <= 4'h0;
                  if (config_i.parity_select == PAR_NONE) begin
                     tx_shift_q[9] <= 1'b1;
                  end
               end
            end
            TX_SHIFT: begin
               if (tick && !remote_mode) begin
                  tx_tick_q <= tx_tick_q + 4'h1;
                  if (tx_tick_q == TICK_LAST) begin
                     tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                     tx_left_q  <= tx_left_q - 4'h1;
                     if (tx_left_q == 4'h1) begin
                        tx_st_q <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   assign tx_line = (tx_st_q == TX_SHIFT) ? tx_shift_q[0] : LINE_IDLE;

   // carrier period and high time from the divider
   // duty select removes one sixteenth of the period per step
   assign car_period = ({4'h0, config_i.carrier_divider} + CARRIER_DIV_OFFSET) << 3;
   assign car_high   = 9'((18'({4'h0, config_i.carrier_divider} + CARRIER_DIV_OFFSET) *
                           18'(CARRIER_DUTY_STEPS - 32'(config_i.carrier_duty_select))) >> 1);

   // Carrier phase counter advanced on each PLL rising edge seen in this domain
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         car_cnt_q <= 9'h000;
      end else if (pll_q && !pll_prev_q) begin
         car_cnt_q <= (car_cnt_q >= car_period - 9'h001) ? 9'h000 : car_cnt_q + 9'h001;
      end
   end

   // echo and remote loopback forward the input pin
   // local loopback holds the pin high, or low when the optical output is inverted
   always_comb begin
      case (config_i.channel_test_select)
         CH_NORMAL: chan_out = tx_line;
         CH_ECHO:   chan_out = pin_q;
         CH_LOCAL:  chan_out = LINE_IDLE;
         CH_REMOTE: chan_out = pin_q;
         default:   chan_out = LINE_IDLE;
      endcase
   end

   // zero carries the carrier, one stays high, invert flips the result
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         line_q <= LINE_IDLE;
      end else if (config_i.optical_link_enable) begin
         line_q <= (chan_out | (car_cnt_q < car_high)) ^ config_i.modulated_output_invert;
      end else begin
         line_q <= chan_out;
      end
   end

   assign serial_out_pin_o = line_q;
   assign receive_holding_o = hold_q;

   // empty only once both registers are drained
   assign flags_o.receive_ready_flag     = rdy_q;
   assign flags_o.transmit_ready_flag    = tx_en_q && !thr_full_q;
   assign flags_o.transmitter_empty_flag = tx_en_q && !thr_full_q && tx_st_q == TX_IDLE;
   assign flags_o.overrun_flag           = ovr_q;
   assign flags_o.parity_error_flag      = parity_error_flag_q;
   assign flags_o.framing_error_flag     = frame_q;

   // DMA requests follow the ready flags
   assign dma_rx_req_o = rdy_q;
   assign dma_tx_req_o = tx_en_q && !thr_full_q;

endmodule

// [logic/uart_optical_pkg.sv]
// Shared constants, types and encodings for the serial port with optical output
package uart_optical_pkg;

   // Bit timing in sampling ticks
   localparam int unsigned TICKS_PER_BIT   = 16;
   localparam logic [3:0]  TICK_LAST       = 4'hf;
   localparam logic [2:0]  START_LOW_LAST  = 3'h7;  // Eighth low sample accepts the start bit
   localparam logic [3:0]  DATA_LAST_IDX   = 4'h7;
   localparam logic [3:0]  PARITY_IDX      = 4'h8;
   localparam logic [3:0]  TX_BITS_PAR     = 4'hb;  // Start, 8 data, parity, stop
   localparam logic [3:0]  TX_BITS_NOPAR   = 4'ha;

   // Parity settings
   localparam logic [2:0]  PAR_EVEN  = 3'h0;
   localparam logic [2:0]  PAR_ODD   = 3'h1;
   localparam logic [2:0]  PAR_SPACE = 3'h2;
   localparam logic [2:0]  PAR_MARK  = 3'h3;
   localparam logic [2:0]  PAR_NONE  = 3'h4;

   // Channel test settings
   localparam logic [1:0]  CH_NORMAL = 2'h0;
   localparam logic [1:0]  CH_ECHO   = 2'h1;
   localparam logic [1:0]  CH_LOCAL  = 2'h2;
   localparam logic [1:0]  CH_REMOTE = 2'h3;

   // Carrier timing: period is 8 * (divider + 8) clock edges of the PLL
   localparam logic [8:0]  CARRIER_DIV_OFFSET = 9'h008;
   localparam int unsigned CARRIER_DUTY_STEPS = 8;

   // Reset values
   localparam logic        LINE_IDLE     = 1'b1;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [2:0]  SYNC_RESET    = 3'h7;

   // Transmit buffer in front of the holding register
   localparam int unsigned TX_BUF_WIDTH = 8;
   localparam int unsigned TX_BUF_DEPTH = 2;

   typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_START, RX_DATA} rx_state_e;
   typedef enum logic       {TX_IDLE, TX_SHIFT} tx_state_e;

   typedef struct packed {
      logic [2:0] parity_select;
      logic [1:0] channel_test_select;
      logic       filter_enable;
      logic       optical_link_enable;
      logic       modulated_output_invert;
      logic [2:0] carrier_duty_select;
      logic [4:0] carrier_divider;
   } config_s;

   typedef struct packed {
      logic receiver_enable_cmd;
      logic receiver_disable_cmd;
      logic receiver_reset_cmd;
      logic transmitter_enable_cmd;
      logic transmitter_disable_cmd;
      logic transmitter_reset_cmd;
      logic clear_error_flags_cmd;
   } command_s;

   typedef struct packed {
      logic receive_ready_flag;
      logic transmit_ready_flag;
      logic transmitter_empty_flag;
      logic overrun_flag;
      logic parity_error_flag;
      logic framing_error_flag;
   } flag_s;

endpackage

// [logic/tx_skid_buffer.sv]
// Two-entry valid/ready buffer in the transmit data path
`timescale 1ns/1ps
module tx_skid_buffer #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Full and empty come straight from the count
   assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem_q[rd_q];

   // Storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// [verification/uart_optical_properties.sv]
// Concurrent checks on the serial port top ports
`timescale 1ns/1ps
module uart_optical_properties
   import uart_optical_pkg::*;
(
   input logic     clk_i,
   input logic     srst_i,
   input config_s  config_i,
   input command_s command_i,
   input logic     rx_read_i,
   input flag_s    flags_o,
   input logic     dma_rx_req_o,
   input logic     dma_tx_req_o,
   input logic     serial_out_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic tx_on_q;

   // Enabled since reset; before that the holding register cannot be full
   always_ff @(posedge clk_i) begin
      if (srst_i || command_i.transmitter_reset_cmd)
         tx_on_q <= 1'b0;
      else if (command_i.transmitter_enable_cmd)
         tx_on_q <= 1'b1;
   end

   AST_RESET_STATE:
   assert property (disable iff (1'b0) srst_i |=> serial_out_pin_o && flags_o == '0) else $error("reset state");
   AST_DMA_REQ:
   assert property (dma_rx_req_o == flags_o.receive_ready_flag && dma_tx_req_o == flags_o.transmit_ready_flag)
      else $error("dma request differs from flag");
   AST_CLEAR_ERRORS:
   assert property (command_i.clear_error_flags_cmd |-> ##2 !(flags_o.overrun_flag || flags_o.parity_error_flag
      || flags_o.framing_error_flag)) else $error("error flags not cleared");
   AST_TX_ENABLE:
   assert property (command_i == 7'h08 && !tx_on_q |=> flags_o.transmit_ready_flag) else $error("no ready");
   AST_TX_RESET:
   assert property (command_i.transmitter_reset_cmd && config_i.channel_test_select == CH_NORMAL
      && !config_i.optical_link_enable |-> ##2 serial_out_pin_o && !flags_o.transmit_ready_flag)
      else $error("transmitter not stopped");
   AST_READY_HOLD:
   assert property (flags_o.receive_ready_flag && !rx_read_i && !command_i.receiver_reset_cmd
      |=> flags_o.receive_ready_flag) else $error("receive ready dropped");
   AST_OVERRUN_STICKY:
   assert property (flags_o.overrun_flag && !command_i.clear_error_flags_cmd
      && !$past(command_i.clear_error_flags_cmd) |=> flags_o.overrun_flag) else $error("overrun dropped");
   AST_EMPTY_READY:
   assert property (flags_o.transmitter_empty_flag |-> flags_o.transmit_ready_flag) else $error("empty not ready");
   AST_LOCAL_IDLE:
   assert property ((config_i.channel_test_select == CH_LOCAL && !config_i.optical_link_enable)[*3]
      |-> serial_out_pin_o) else $error("output not idle in local loop");

   // Main scenarios reached
   cover property (flags_o.overrun_flag && flags_o.framing_error_flag);
   cover property (flags_o.parity_error_flag);
   cover property ($rose(flags_o.transmitter_empty_flag));
endmodule

bind uart_optical uart_optical_properties u_props (.clk_i, .srst_i, .config_i, .command_i, .rx_read_i,
   .flags_o, .dma_rx_req_o, .dma_tx_req_o, .serial_out_pin_o);

// [verification/serial_peer.sv]
// Remote serial device: drives the receive pin, samples the transmit pin
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT_CLKS = 32
) (
   input  logic clk_i,
   input  logic line_i,
   output logic line_o
);
   initial line_o = 1'b1;

   // Bits go out LSB first, each held clks cycles; line idles high after
   task automatic send(input logic [10:0] bits, input int clks);
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i) line_o <= bits[i];
         repeat (clks - 1) @(posedge clk_i);
      end
      @(posedge clk_i) line_o <= 1'b1;
   endtask

   // Mid-bit sampling; returns at mid stop so a following start edge is not missed
   task automatic recv(output logic [10:0] bits);
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 11; i++) begin
         if (i > 0)
            repeat (BIT_CLKS) @(posedge clk_i);
         bits[i] = line_i;
      end
   endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the serial port with optical output
`timescale 1ns/1ps
module tb;
   import uart_optical_pkg::*;
   typedef struct {logic [2:0] par; logic [7:0] data; logic [10:0] frame;} row_s;
   // Frames read stop, parity, data, start from the top bit down
   row_s        rows [5] = '{'{PAR_EVEN, 8'ha5, 11'h54a}, '{PAR_ODD, 8'ha5, 11'h74a},
      '{PAR_SPACE, 8'h3c, 11'h478}, '{PAR_MARK, 8'h3c, 11'h678}, '{PAR_NONE, 8'h81, 11'h702}};
   logic        clk_i, srst_i, tx_valid, tx_ready, rx_read, pll, serial_in, serial_out;
   logic [7:0]  tx_data, holding;
   logic [10:0] got;
   config_s     cfg;
   command_s    cmd;
   flag_s       flags;
   int          n_fail = 0;
   int          n_tests = 0;
   int          n_high = 0;

   // Divisor 2 gives 32 clocks a bit
   uart_optical u_dut (.clk_i, .srst_i, .baud_divisor_i(16'h0002), .config_i(cfg), .command_i(cmd),
      .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data), .receive_holding_o(holding),
      .rx_read_i(rx_read), .flags_o(flags), .dma_rx_req_o(), .dma_tx_req_o(),
      .serial_in_pin_i(serial_in), .main_pll_clock_i(pll), .serial_out_pin_o(serial_out));
   serial_peer #(.BIT_CLKS(32)) u_peer (.clk_i, .line_i(serial_out), .line_o(serial_in));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Carrier source, slow enough to pass the pin filter
   always begin
      repeat (3) @(posedge clk_i);
      pll <= ~pll;
   end

   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Command bits: rx en, dis, reset, tx en, dis, reset, clear errors
   task automatic pulse(input command_s c);
      @(posedge clk_i) cmd <= c;
      @(posedge clk_i) cmd <= '0;
   endtask
   // Holds the write until ready is seen at a sampling edge
   task automatic push(input logic [7:0] d);
      @(posedge clk_i) tx_data <= d;
      tx_valid <= 1'b1;
      do @(negedge clk_i); while (tx_ready !== 1'b1);
      @(posedge clk_i) tx_valid <= 1'b0;
   endtask
   task automatic rd();
      @(posedge clk_i) rx_read <= 1'b1;
      @(posedge clk_i) rx_read <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 8000 cycles
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      final_report();
   end

   initial begin
      srst_i = 1'b1;
      cfg = '0;
      cmd = '0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      rx_read = 1'b0;
      pll = 1'b0;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      settle(1);
      check({flags, serial_out}, 7'h01);
      pulse(7'h48);
      // Each parity code out and back in
      foreach (rows[i]) begin
         @(posedge clk_i) cfg.parity_select <= rows[i].par;
         fork
            push(rows[i].data);
            u_peer.recv(got);
         join
         check(got, rows[i].frame);
         u_peer.send(rows[i].frame, 32);
         settle(4);
         check({flags.parity_error_flag, holding}, {1'b0, rows[i].data});
         rd();
         settle(1);
         check(flags.receive_ready_flag, 1'b0);
      end
      // Unread character then one with a low stop bit
      u_peer.send(11'h702, 32);
      u_peer.send(11'h502, 32);
      // Tail of the low stop bit starts a ghost character
      settle(300);
      check({flags.receive_ready_flag, flags.overrun_flag, flags.framing_error_flag}, 3'h7);
      pulse(7'h01);
      settle(3);
      check({flags.receive_ready_flag, flags.overrun_flag, flags.framing_error_flag}, 3'h4);
      rd();
      @(posedge clk_i) cfg.parity_select <= PAR_EVEN;
      u_peer.send(11'h74a, 32);
      settle(4);
      check({flags.receive_ready_flag, flags.parity_error_flag}, 2'h3);
      rd();
      pulse(7'h21);
      u_peer.send(11'h54a, 32);
      u_peer.send(11'h7fe, 12);
      check(flags.receive_ready_flag, 1'b0);
      pulse(7'h40);
      u_peer.send(11'h7fe, 12);
      settle(320);
      check(flags.receive_ready_flag, 1'b0);
      fork
         u_peer.send(11'h54a, 32);
         begin
            repeat (150) @(posedge clk_i);
            pulse(7'h10);
         end
      join
      settle(4);
      check(flags.receive_ready_flag, 1'b0);
      pulse(7'h40);
      // Back-to-back writes fill the holding register
      fork
         begin
            push(8'h96);
            push(8'h69);
            settle(2);
            check({flags.transmit_ready_flag, flags.transmitter_empty_flag}, 2'h0);
         end
         begin
            u_peer.recv(got);
            u_peer.recv(got);
         end
      join
      check(got, 11'h4d2);
      settle(24);
      check({flags.transmit_ready_flag, flags.transmitter_empty_flag}, 2'h3);
      push(8'h55);
      // Reset lands in the start bit so a stopped line shows high
      settle(20);
      pulse(7'h02);
      settle(2);
      check({flags.transmit_ready_flag, serial_out}, 2'h1);
      pulse(7'h08);
      @(posedge clk_i) cfg.channel_test_select <= CH_LOCAL;
      push(8'h5a);
      settle(400);
      check({serial_out, holding}, 9'h15a);
      rd();
      // Echo returns the pin; the filtered receiver still takes it
      @(posedge clk_i) {cfg.channel_test_select, cfg.filter_enable} <= 3'h3;
      fork
         u_peer.send(11'h54a, 32);
         u_peer.recv(got);
      join
      settle(24);
      check(got, 11'h54a);
      check({flags.receive_ready_flag, holding}, 9'h1a5);
      // Low line in optical echo: carrier high half of each 384-clock period
      @(posedge clk_i) {cfg.channel_test_select, cfg.filter_enable, cfg.optical_link_enable} <= 4'h5;
      fork
         u_peer.send(11'h000, 40);
         begin
            settle(20);
            repeat (384) @(negedge clk_i) n_high += int'(serial_out);
         end
      join
      check(11'(n_high), 11'h0c0);
      @(posedge clk_i) {cfg.channel_test_select, cfg.optical_link_enable, cfg.modulated_output_invert} <= 4'h3;
      settle(4);
      check(serial_out, 1'b0);
      final_report();
   end
endmodule
